// file: rhb_pkg.sv
// Package for the host bus interface of the real-time clock block.
// Assumes a single 250 MHz core clock; all bus pins arrive asynchronously.
package rhb_pkg;

  // ********************************************************************
  // Register map and fields
  // ********************************************************************
  localparam logic [4:0] RHB_OFS_STATUS = 5'h10; // Read side of 0x10
  localparam logic [4:0] RHB_OFS_MASK = 5'h10;   // Write side of 0x10
  localparam logic [4:0] RHB_OFS_CMD = 5'h11;
  localparam int RHB_CMD_FSEL_LSB = 0;
  localparam int RHB_CMD_RUN_BIT = 3;
  localparam int RHB_CMD_IEN_BIT = 4;
  localparam int RHB_CMD_TEST_BIT = 5;
  localparam int RHB_STAT_GLOBAL_BIT = 7;
  localparam int RHB_STAT_SEC_BIT = 3;
  localparam logic [7:0] RHB_MASK_RST = 8'h00;
  localparam logic [7:0] RHB_CMD_RST = 8'h00;
  localparam logic [7:0] RHB_STAT_RST = 8'h00;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int RHB_CLK_MHZ = 250;
  localparam int RHB_TICK_4K_HZ = 4000;
  localparam int RHB_TICK_100_HZ = 100;
  localparam int RHB_DIV_100 = RHB_TICK_4K_HZ / RHB_TICK_100_HZ;
  // Oscillator cycles per 4 kHz tick, per frequency code
  localparam int RHB_DIV_32K = 8;      // 32.768 kHz, non-integer ratio approximated
  localparam int RHB_DIV_1M = 262;
  localparam int RHB_DIV_2M = 524;
  localparam int RHB_DIV_4M = 1049;

  // Bundle of synchronised bus strobes; rd_n, wr_n and cs_n active low, ale active high
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic ale;
  } rhb_strobe_s;

endpackage

// file: rhb_host_bus.sv
// Host bus interface of the real-time clock: strobe decode, address latch,
// mask/command registers, tick dividers and interrupt status.
// Assumes the counter core sits outside and takes the tick and flag ports.
`timescale 1ns/100ps
module rhb_host_bus
  import rhb_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic CS_N_I,
  input wire logic ALE_I,
  input wire logic [4:0] ADDR_I,
  input wire logic [7:0] DATA_I,
  input wire logic [7:0] RDATA_I,
  input wire logic OSC_TICK_I,
  input wire logic [6:1] CNT_INC_I,
  input wire logic ALARM_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_N_O,
  output logic [4:0] ADDR_O,
  output logic CNT_WR_O,
  output logic CNT_RD_O,
  output logic TICK_100_O,
  output logic IRQ_N_O
);

  // ********************************************************************
  // Checks
  // ********************************************************************
  // Elaboration-time refusal: the filter below is built for exactly three stages
  if (SYNC_STAGES != 3) begin : g_bad_stages
    $error("SYNC_STAGES must be 3");
  end

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  rhb_strobe_s s1_reg, s2_reg, s3_reg;
  logic [4:0] a1_reg, a2_reg;
  logic [7:0] d1_reg, d2_reg;
  logic o1_reg, o2_reg, o3_reg;
  // Three stages for strobes and oscillator, two for address and data; a strobe change counts once stages two and three agree
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1};
      s2_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1};
      s3_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1};
      {o1_reg, o2_reg, o3_reg} <= 3'h0;
      {a1_reg, a2_reg} <= 10'h000;
      {d1_reg, d2_reg} <= 16'h0000;
    end else begin
      s1_reg <= '{rd_n: RD_N_I, wr_n: WR_N_I, cs_n: CS_N_I, ale: ALE_I};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      {o1_reg, o2_reg, o3_reg} <= {OSC_TICK_I, o1_reg, o2_reg};
      a1_reg <= ADDR_I;
      a2_reg <= a1_reg;
      d1_reg <= DATA_I;
      d2_reg <= d1_reg;
    end
  end

  // Filtered levels: hold the old value until stages two and three agree
  rhb_strobe_s flt_reg;
  logic osc_flt_reg;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flt_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1};
      osc_flt_reg <= 1'b0;
    end else begin
      flt_reg <= rhb_strobe_s'((s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg)));
      osc_flt_reg <= (o2_reg == o3_reg) ? o3_reg : osc_flt_reg;
    end
  end

  // ********************************************************************
  // Address latch and strobe decode
  // ********************************************************************
  logic [4:0] alat_reg;
  logic cslat_reg;
  logic ale_prev_reg, rd_prev_reg, wr_prev_reg;
  wire ale_fall = ale_prev_reg & ~flt_reg.ale;
  // While latch enable is high the latch is transparent, so a direct bus passes through
  wire [4:0] addr_eff = flt_reg.ale ? a2_reg : alat_reg;
  wire cs_eff_n = flt_reg.ale ? flt_reg.cs_n : cslat_reg;
  // Grounded chip select leaves the strobes alone in control
  wire sel = ~cs_eff_n;
  wire rd_act = ~flt_reg.rd_n & sel;
  wire wr_act = ~flt_reg.wr_n & sel;
  wire rd_start = rd_act & rd_prev_reg;
  wire rd_end = ~rd_act & ~rd_prev_reg;
  wire wr_start = wr_act & wr_prev_reg;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alat_reg <= 5'h00;
      cslat_reg <= 1'b1;
      ale_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end else begin
      ale_prev_reg <= flt_reg.ale;
      rd_prev_reg <= ~rd_act;
      wr_prev_reg <= ~wr_act;
      if (ale_fall) begin
        alat_reg <= a2_reg;
        cslat_reg <= flt_reg.cs_n;
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [7:0] mask_reg, cmd_reg, stat_reg;
  wire hit_mask = addr_eff == RHB_OFS_MASK;
  wire hit_cmd = addr_eff == RHB_OFS_CMD;
  wire hit_stat = addr_eff == RHB_OFS_STATUS;
  // Write takes effect once per strobe, at its synchronised start
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mask_reg <= RHB_MASK_RST;
      cmd_reg <= RHB_CMD_RST;
    end else if (wr_start) begin
      if (hit_mask) begin
        mask_reg <= d2_reg;
      end
      if (hit_cmd) begin
        cmd_reg <= d2_reg;
      end
    end
  end

  // ********************************************************************
  // Tick generation
  // ********************************************************************
  logic [10:0] div_reg;
  logic [5:0] d100_reg;
  logic osc_prev_reg, tick_reg;
  wire osc_rise = osc_flt_reg & ~osc_prev_reg;
  wire [1:0] fsel = cmd_reg[RHB_CMD_FSEL_LSB +: 2];
  wire [10:0] div_top = (fsel == 2'd0) ? 11'(RHB_DIV_32K - 1) : (fsel == 2'd1) ? 11'(RHB_DIV_1M - 1) :
                        (fsel == 2'd2) ? 11'(RHB_DIV_2M - 1) : 11'(RHB_DIV_4M - 1);
  wire tick_4k = osc_rise & (div_reg == div_top);
  wire tick_raw = (d100_reg == 6'(RHB_DIV_100 - 1)) & tick_4k;
  // Test mode feeds the hundredths straight from the oscillator
  wire tick_src = cmd_reg[RHB_CMD_TEST_BIT] ? osc_rise : tick_raw;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_reg <= 11'h000;
      d100_reg <= 6'h00;
      osc_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_flt_reg;
      if (osc_rise) begin
        div_reg <= tick_4k ? 11'h000 : div_reg + 11'h001;
      end
      if (tick_4k) begin
        d100_reg <= tick_raw ? 6'h00 : d100_reg + 6'h01;
      end
      tick_reg <= tick_src & cmd_reg[RHB_CMD_RUN_BIT];
    end
  end

  // ********************************************************************
  // Interrupt status
  // ********************************************************************
  // Flags set on any increment regardless of mask; set wins over the read clear
  wire [7:0] ev = {1'b0, CNT_INC_I, ALARM_I};
  wire fire = cmd_reg[RHB_CMD_IEN_BIT] & |(ev & mask_reg & 8'h7F);
  logic irq_reg;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stat_reg <= RHB_STAT_RST;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= ((rd_end & hit_stat) ? 8'h00 : stat_reg) | ev | {fire, 7'h00};
      if (fire) begin
        irq_reg <= 1'b1;
      end else if (rd_start & hit_stat) begin
        irq_reg <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Status answered locally; everything else comes from the counter core
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DATA_O <= 8'h00;
      DATA_OE_N_O <= 1'b1;
      ADDR_O <= 5'h00;
      CNT_WR_O <= 1'b0;
      CNT_RD_O <= 1'b0;
      TICK_100_O <= 1'b0;
      IRQ_N_O <= 1'b1;
    end else begin
      DATA_O <= hit_stat ? stat_reg : RDATA_I;
      DATA_OE_N_O <= ~rd_act;
      ADDR_O <= addr_eff;
      CNT_WR_O <= wr_start & ~hit_mask & ~hit_cmd;
      CNT_RD_O <= rd_start & ~hit_stat;
      TICK_100_O <= tick_reg;
      IRQ_N_O <= ~irq_reg;
    end
  end

endmodule

// file: rhb_host_bus_assertions.sv
// Checker for the host bus block, bound to the top module's ports.
// Assumes strobes last and are spaced at least 6 clocks.
`timescale 1ns/100ps
module rhb_host_bus_chk
  import rhb_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic CS_N_I,
  input wire logic ALE_I,
  input wire logic DATA_OE_N_O,
  input wire logic [4:0] ADDR_O,
  input wire logic CNT_WR_O,
  input wire logic CNT_RD_O,
  input wire logic IRQ_N_O
);
  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Selected read is answered within seven clocks of the strobe, allowing for the synchroniser delay
  property p_rd_ans;
    ($fell(RD_N_I) && !CS_N_I && ALE_I) ##1 (!RD_N_I && !CS_N_I)[*7] |-> !DATA_OE_N_O;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle; RD_N_I[*8] |-> DATA_OE_N_O; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("bus driven without read");
  property p_desel; (CS_N_I && ALE_I)[*8] |-> DATA_OE_N_O; endproperty
  a_desel: assert property (p_desel) else $error("bus driven while deselected");
  // One pulse per access, so a slow strobe is never acted on twice
  property p_wr_once; CNT_WR_O |=> !CNT_WR_O[*5]; endproperty
  a_wr_once: assert property (p_wr_once) else $error("write pulse repeated");
  property p_rd_once; CNT_RD_O |=> !CNT_RD_O[*5]; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read pulse repeated");
  property p_wr_cause; CNT_WR_O |-> !$past(WR_N_I, 3); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write pulse without strobe");
  property p_irq_rel; $fell(DATA_OE_N_O) && ADDR_O == RHB_OFS_STATUS |-> ##[0:3] IRQ_N_O; endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("status read kept interrupt");
  property p_irq_hold; RD_N_I[*6] ##0 !IRQ_N_O |=> !IRQ_N_O; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without read");
  c_wr: cover property (!CNT_WR_O ##1 CNT_WR_O);
  c_rd: cover property (!CNT_RD_O ##1 CNT_RD_O);
  c_irq: cover property ($fell(IRQ_N_O));
endmodule
bind rhb_host_bus rhb_host_bus_chk #(.SYNC_STAGES(SYNC_STAGES)) u_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I),
  .RD_N_I(RD_N_I),
  .WR_N_I(WR_N_I),
  .CS_N_I(CS_N_I),
  .ALE_I(ALE_I),
  .DATA_OE_N_O(DATA_OE_N_O),
  .ADDR_O(ADDR_O),
  .CNT_WR_O(CNT_WR_O),
  .CNT_RD_O(CNT_RD_O),
  .IRQ_N_O(IRQ_N_O)
);

// file: rhb_host_model.sv
// Microprocessor model driving the block's strobes, address and data.
// Assumes one shared core clock; requests change just after rising edges.
`timescale 1ns/100ps
module rhb_host_model (
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic oe_n_i,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic cs_n_o = 1'b1,
  output logic ale_o = 1'b1,
  output logic [4:0] addr_o = 5'h00,
  output logic [7:0] data_o = 8'h00
);
  // ********************************************************************
  // Bus cycles
  // ********************************************************************
  // Address and chip select held for the whole strobe, data read at release
  task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d, input logic cs,
                        output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    cs_n_o <= cs;
    if (rd) rd_n_o <= 1'b0;
    else wr_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    q = oe_n_i ? ~data_i : data_i; // Undriven bus shows the inverse, never a stale value
    oe = oe_n_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b1;
    data_o <= ~d; // Released lines do not keep the last value
    repeat (8) @(posedge clk_i);
  endtask
  // Multiplexed address phase; hi leaves the latch transparent
  task automatic latch(input logic [4:0] a, input logic cs, input logic hi);
    @(posedge clk_i);
    addr_o <= a;
    cs_n_o <= cs;
    ale_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    ale_o <= hi;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// file: tb_rhb_host_bus.sv
// Testbench for the host bus block: bus cycles through the host model.
// Assumes a 250 MHz core clock and a counter core modelled by the bench.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_rhb_host_bus;
  import rhb_pkg::*;
  logic CORE_CLK_I = 1'b0, RESETN_I = 1'b0, OSC_TICK_I = 1'b0, ALARM_I = 1'b0;
  logic RD_N_I, WR_N_I, CS_N_I, ALE_I, DATA_OE_N_O, CNT_WR_O, CNT_RD_O, TICK_100_O, IRQ_N_O, oe;
  logic [4:0] ADDR_I, ADDR_O;
  logic [7:0] DATA_I, DATA_O, q, RDATA_I = 8'hA5;
  logic [6:1] CNT_INC_I = 6'h00;
  logic [2:0] osc_div = 3'h0;
  int mismatches = 0, total_checks = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, tick_cnt = 0, t0, t1;
  rhb_host_bus u_dut (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I),
    .CS_N_I(CS_N_I), .ALE_I(ALE_I), .ADDR_I(ADDR_I), .DATA_I(DATA_I), .RDATA_I(RDATA_I),
    .OSC_TICK_I(OSC_TICK_I), .CNT_INC_I(CNT_INC_I), .ALARM_I(ALARM_I), .DATA_O(DATA_O),
    .DATA_OE_N_O(DATA_OE_N_O), .ADDR_O(ADDR_O), .CNT_WR_O(CNT_WR_O), .CNT_RD_O(CNT_RD_O),
    .TICK_100_O(TICK_100_O), .IRQ_N_O(IRQ_N_O));
  rhb_host_model u_host (.clk_i(CORE_CLK_I), .data_i(DATA_O), .oe_n_i(DATA_OE_N_O), .rd_n_o(RD_N_I),
    .wr_n_o(WR_N_I), .cs_n_o(CS_N_I), .ale_o(ALE_I), .addr_o(ADDR_I), .data_o(DATA_I));
  // ********************************************************************
  // Clock, oscillator, event counters and hang guard
  // ********************************************************************
  always #2 CORE_CLK_I = ~CORE_CLK_I;
  always @(posedge CORE_CLK_I) begin
    osc_div <= osc_div + 3'h1;
    OSC_TICK_I <= osc_div[2]; // Oscillator period of 8 core clocks
    wr_cnt <= wr_cnt + int'(CNT_WR_O);
    rd_cnt <= rd_cnt + int'(CNT_RD_O);
    tick_cnt <= tick_cnt + int'(TICK_100_O);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pulse(input int n);
    @(posedge CORE_CLK_I);
    CNT_INC_I <= 6'h01 << (n - 1);
    @(posedge CORE_CLK_I);
    CNT_INC_I <= 6'h00;
    repeat (4) @(posedge CORE_CLK_I);
  endtask
  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    repeat (12) @(posedge CORE_CLK_I);
    RESETN_I <= 1'b1;
    repeat (4) @(posedge CORE_CLK_I);
    `CHK(IRQ_N_O, 1'b1)
    `CHK(DATA_OE_N_O, 1'b1)
    u_host.access(1'b0, RHB_OFS_MASK, 8'h00, 1'b0, q, oe);
    u_host.access(1'b0, RHB_OFS_CMD, 8'h18, 1'b0, q, oe);
    u_host.access(1'b0, RHB_OFS_MASK, 8'h08, 1'b0, q, oe);
    pulse(1);
    `CHK(IRQ_N_O, 1'b1)
    pulse(3);
    `CHK(IRQ_N_O, 1'b0)
    u_host.access(1'b1, RHB_OFS_STATUS, 8'h00, 1'b0, q, oe);
    `CHK(q, 8'h8A)
    `CHK(IRQ_N_O, 1'b1)
    u_host.access(1'b1, RHB_OFS_STATUS, 8'h00, 1'b0, q, oe);
    `CHK(q, 8'h00)
    u_host.access(1'b1, 5'h03, 8'h00, 1'b0, q, oe);
    `CHK({oe, q, rd_cnt}, {1'b0, 8'hA5, 32'd1})
    u_host.access(1'b1, 5'h03, 8'h00, 1'b1, q, oe);
    `CHK({oe, rd_cnt}, {1'b1, 32'd1})
    u_host.access(1'b0, 5'h02, 8'h5C, 1'b0, q, oe);
    `CHK({ADDR_O, wr_cnt}, {5'h02, 32'd1})
    u_host.latch(5'h06, 1'b0, 1'b0);
    u_host.access(1'b0, 5'h1F, 8'h33, 1'b0, q, oe);
    `CHK({ADDR_O, wr_cnt}, {5'h06, 32'd2})
    u_host.latch(5'h07, 1'b1, 1'b0);
    u_host.access(1'b0, 5'h1F, 8'h33, 1'b0, q, oe);
    `CHK(wr_cnt, 2)
    u_host.latch(5'h00, 1'b1, 1'b1);
    u_host.access(1'b0, RHB_OFS_CMD, 8'h38, 1'b0, q, oe);
    t0 = tick_cnt;
    repeat (200) @(posedge CORE_CLK_I);
    `CHK(tick_cnt - t0 inside {[24:26]}, 1'b1)
    u_host.access(1'b0, RHB_OFS_CMD, 8'h10, 1'b0, q, oe);
    t0 = tick_cnt;
    repeat (200) @(posedge CORE_CLK_I);
    `CHK(tick_cnt - t0, 0)
    // Normal run on code 0: tick spacing is divider times 40, eight core clocks per oscillator period
    u_host.access(1'b0, RHB_OFS_CMD, 8'h08, 1'b0, q, oe);
    t0 = tick_cnt;
    while (tick_cnt == t0) @(posedge CORE_CLK_I);
    t1 = cyc;
    t0 = tick_cnt;
    while (tick_cnt == t0) @(posedge CORE_CLK_I);
    `CHK(cyc - t1, RHB_DIV_32K * RHB_DIV_100 * 8)
    close_out();
  end
endmodule
